// file: inc/can_mode_pkg.sv
package can_mode_pkg;
	// register byte addresses on apb
	localparam logic [7:0] ctl0_addr = 8'h00;
	localparam logic [7:0] ctl1_addr = 8'h04;
	localparam logic [7:0] bus_in_addr = 8'h08;
	localparam logic [7:0] timer_addr = 8'h0c;
	localparam logic [7:0] stamp_addr = 8'h10;
	// control register 0 field positions
	localparam int received_frame_flag_bit = 7;
	localparam int receiver_active_flag_bit = 6;
	localparam int stop_in_wait_bit = 5;
	localparam int bus_synced_flag_bit = 4;
	localparam int time_bit = 3;
	localparam int wake_enable_bit = 2;
	localparam int sleep_request_bit = 1;
	localparam int init_request_bit = 0;
	// control register 1: ack flags
	localparam int sleep_ack_bit = 1;
	localparam int init_ack_bit = 0;
	localparam logic [7:0] ctl0_reset = 8'h01;
	localparam logic [7:0] ctl1_reset = 8'h01;
	// resync counts
	localparam int recessive_run = 11;
	localparam int busoff_runs = 128;
	typedef enum logic [1:0] {
		st_init = 2'b00,
		st_wait_sync = 2'b01,
		st_run = 2'b10,
		st_sleep = 2'b11
	} mode_t;
	typedef struct packed {
		logic rx_bit;
		logic bit_tick;
		logic frame_ok;
		logic rx_busy;
		logic ack_seen;
		logic tx_empty;
		logic bus_off;
		logic wake_irq;
		logic cpu_wait;
		logic loopback;
	} bus_in_t;
endpackage : can_mode_pkg

// file: hw/can_mode_control.sv
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module can_mode_control (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// protocol engine side
	input wire can_mode_pkg::bus_in_t bus_in,
	input wire logic tx_bit,
	// outputs
	output logic transmit_output_pin,
	output logic [15:0] stamp_value,
	output logic stamp_strobe,
	output logic bus_clk_gate,
	output logic abort_pulse,
	output logic cfg_reset_pulse,
	output logic [7:0] can_control_1_out
);
	logic [7:0] ctl0_r;
	logic [7:0] ctl1_r;
	logic [15:0] timer_r;
	logic [3:0] run_r;
	logic [7:0] runs_r;
	can_mode_pkg::mode_t mode_r;
	logic init_mode;
	logic wr;
	logic ctl0_wr;
	logic ctl1_wr;
	logic [7:0] wd;
	logic wake_hit;
	logic run_done;

	assign init_mode = ctl0_r[can_mode_pkg::init_request_bit] & ctl1_r[can_mode_pkg::init_ack_bit];
	assign wr = psel & penable & pwrite;
	assign wd = pwdata[7:0];
	assign ctl0_wr = wr && paddr == can_mode_pkg::ctl0_addr;
	assign ctl1_wr = wr && paddr == can_mode_pkg::ctl1_addr && init_mode;
	assign wake_hit = (mode_r == can_mode_pkg::st_sleep) & ctl0_r[can_mode_pkg::wake_enable_bit]
		& ~bus_in.rx_bit;
	assign run_done = run_r == 4'(can_mode_pkg::recessive_run - 1) && bus_in.bit_tick
		&& bus_in.rx_bit;

	////////////////////////////////////////////////////////////////////////////////
	// control register 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl0_r <= can_mode_pkg::ctl0_reset;
		end else begin
			// flag set beats write-one clear
			if (bus_in.frame_ok && !bus_in.loopback && !init_mode) begin
				ctl0_r[can_mode_pkg::received_frame_flag_bit] <= 1'b1;
			end else if (ctl0_wr && !init_mode && wd[can_mode_pkg::received_frame_flag_bit]) begin
				ctl0_r[can_mode_pkg::received_frame_flag_bit] <= 1'b0;
			end
			// read-only status follows the engine and the mode sequencer; cpu data not used
			ctl0_r[can_mode_pkg::receiver_active_flag_bit] <= bus_in.rx_busy & ~bus_in.loopback
				& (mode_r == can_mode_pkg::st_run);
			ctl0_r[can_mode_pkg::bus_synced_flag_bit] <= (mode_r == can_mode_pkg::st_run)
				& ~ctl0_r[can_mode_pkg::init_request_bit];
			if (init_mode) begin
				ctl0_r[can_mode_pkg::stop_in_wait_bit] <= 1'b0;
				ctl0_r[can_mode_pkg::time_bit] <= 1'b0;
				ctl0_r[can_mode_pkg::received_frame_flag_bit] <= 1'b0;
			end else if (ctl0_wr && !ctl1_r[can_mode_pkg::init_ack_bit]) begin
				ctl0_r[can_mode_pkg::stop_in_wait_bit] <= wd[can_mode_pkg::stop_in_wait_bit];
				ctl0_r[can_mode_pkg::time_bit] <= wd[can_mode_pkg::time_bit] &
					~ctl0_r[can_mode_pkg::init_request_bit];
			end
			if (ctl0_wr) begin
				ctl0_r[can_mode_pkg::wake_enable_bit] <= wd[can_mode_pkg::wake_enable_bit];
			end
			// sleep request
			if (wake_hit) begin
				ctl0_r[can_mode_pkg::sleep_request_bit] <= 1'b0;
			end else if (ctl0_wr) begin
				if (wd[can_mode_pkg::sleep_request_bit] && !bus_in.wake_irq) begin
					ctl0_r[can_mode_pkg::sleep_request_bit] <= 1'b1;
				end else if (!wd[can_mode_pkg::sleep_request_bit] && ctl1_r[can_mode_pkg::sleep_ack_bit]) begin
					ctl0_r[can_mode_pkg::sleep_request_bit] <= 1'b0;
				end
			end
			// init request
			if (ctl0_wr) begin
				if (wd[can_mode_pkg::init_request_bit]) begin
					ctl0_r[can_mode_pkg::init_request_bit] <= 1'b1;
				end else if (ctl1_r[can_mode_pkg::init_ack_bit]) begin
					ctl0_r[can_mode_pkg::init_request_bit] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register 1: config bits, acks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl1_r <= can_mode_pkg::ctl1_reset;
		end else begin
			if (ctl1_wr) begin
				ctl1_r[7:2] <= wd[7:2];
			end
			ctl1_r[can_mode_pkg::init_ack_bit] <= ctl0_r[can_mode_pkg::init_request_bit];
			ctl1_r[can_mode_pkg::sleep_ack_bit] <= ctl0_r[can_mode_pkg::sleep_request_bit] & ~wake_hit
				& (ctl1_r[can_mode_pkg::sleep_ack_bit] | (bus_in.tx_empty & ~bus_in.rx_busy))
				& ~ctl0_r[can_mode_pkg::init_request_bit];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode sequencer; error counters live in the engine and are untouched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= can_mode_pkg::st_init;
		end else begin
			case (mode_r)
				can_mode_pkg::st_init: begin
					if (!ctl0_r[can_mode_pkg::init_request_bit] && !ctl1_r[can_mode_pkg::init_ack_bit]) begin
						mode_r <= can_mode_pkg::st_wait_sync;
					end
				end
				can_mode_pkg::st_wait_sync: begin
					if (ctl0_r[can_mode_pkg::init_request_bit]) begin
						mode_r <= can_mode_pkg::st_init;
					end else if (run_done && (!bus_in.bus_off ||
						runs_r == 8'(can_mode_pkg::busoff_runs - 1))) begin
						mode_r <= can_mode_pkg::st_run;
					end
				end
				can_mode_pkg::st_run: begin
					if (ctl0_r[can_mode_pkg::init_request_bit]) begin
						mode_r <= can_mode_pkg::st_init;
					end else if (ctl1_r[can_mode_pkg::sleep_ack_bit]) begin
						mode_r <= can_mode_pkg::st_sleep;
					end
				end
				can_mode_pkg::st_sleep: begin
					if (ctl0_r[can_mode_pkg::init_request_bit]) begin
						mode_r <= can_mode_pkg::st_init;
					end else if (!ctl0_r[can_mode_pkg::sleep_request_bit]) begin
						mode_r <= can_mode_pkg::st_wait_sync;
					end
				end
				default: mode_r <= can_mode_pkg::st_init;
			endcase
		end
	end

	// recessive run counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r <= 4'h0;
			runs_r <= 8'h00;
		end else if (mode_r != can_mode_pkg::st_wait_sync) begin
			run_r <= 4'h0;
			runs_r <= 8'h00;
		end else if (bus_in.bit_tick) begin
			if (!bus_in.rx_bit || run_done) begin
				run_r <= 4'h0;
			end else begin
				run_r <= run_r + 4'h1;
			end
			if (run_done) begin
				runs_r <= runs_r + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// timestamp timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_r <= 16'h0000;
			stamp_value <= 16'h0000;
			stamp_strobe <= 1'b0;
		end else begin
			if (!ctl0_r[can_mode_pkg::time_bit]) begin
				timer_r <= 16'h0000;
			end else if (bus_in.bit_tick) begin
				timer_r <= timer_r + 16'h0001;
			end
			stamp_strobe <= ctl0_r[can_mode_pkg::time_bit] & bus_in.ack_seen;
			if (ctl0_r[can_mode_pkg::time_bit] && bus_in.ack_seen) begin
				stamp_value <= timer_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pins and side effects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_output_pin <= 1'b1;
			bus_clk_gate <= 1'b1;
			abort_pulse <= 1'b0;
			cfg_reset_pulse <= 1'b0;
			can_control_1_out <= can_mode_pkg::ctl1_reset;
		end else begin
			// recessive from the write cycle itself, not one later
			transmit_output_pin <= (ctl0_wr && wd[can_mode_pkg::init_request_bit]) ? 1'b1 :
				(ctl0_r[can_mode_pkg::init_request_bit] || mode_r != can_mode_pkg::st_run) ? 1'b1 :
				tx_bit;
			bus_clk_gate <= ~(bus_in.cpu_wait & ctl0_r[can_mode_pkg::stop_in_wait_bit]);
			abort_pulse <= ctl0_wr & wd[can_mode_pkg::init_request_bit]
				& ~ctl0_r[can_mode_pkg::init_request_bit];
			cfg_reset_pulse <= ctl0_r[can_mode_pkg::init_request_bit]
				& ~ctl1_r[can_mode_pkg::init_ack_bit];
			can_control_1_out <= ctl1_r;
		end
	end

	// apb: zero-wait reads and writes; unmapped reads zero, slverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > can_mode_pkg::stamp_addr | paddr[1:0] != 2'b00);
			if (psel && !penable) begin
				case (paddr)
					can_mode_pkg::ctl0_addr: prdata <= {24'h000000, ctl0_r};
					can_mode_pkg::ctl1_addr: prdata <= {24'h000000, ctl1_r};
					can_mode_pkg::bus_in_addr: prdata <= {22'h0, bus_in};
					can_mode_pkg::timer_addr: prdata <= {16'h0000, timer_r};
					can_mode_pkg::stamp_addr: prdata <= {16'h0000, stamp_value};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence init_req_seq;
		ctl0_wr && wd[can_mode_pkg::init_request_bit];
	endsequence
	AST_TX_RECESSIVE: assert property (@(posedge pclk) disable iff (!presetn)
		init_req_seq |=> transmit_output_pin) else $error("tx not recessive on init request");
	AST_INIT_ACK: assert property (@(posedge pclk) disable iff (!presetn)
		init_req_seq |=> ##1 ctl1_r[can_mode_pkg::init_ack_bit]) else $error("init ack missing");
	AST_TIME_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		init_mode |=> !ctl0_r[can_mode_pkg::time_bit]) else $error("timer enabled in init");
	AST_TIMER_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		!ctl0_r[can_mode_pkg::time_bit] |=> timer_r == 16'h0000) else $error("timer not cleared");
	AST_RECEIVED_FRAME_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
		bus_in.frame_ok && !bus_in.loopback && !init_mode |=> ctl0_r[can_mode_pkg::received_frame_flag_bit])
		else $error("frame flag lost");
	AST_SLP_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
		!ctl0_r[can_mode_pkg::sleep_request_bit] && bus_in.wake_irq |=> !ctl0_r[can_mode_pkg::sleep_request_bit])
		else $error("sleep set while wake flag");
	AST_INIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		ctl0_r[can_mode_pkg::init_request_bit] && !ctl1_r[can_mode_pkg::init_ack_bit]
		|=> ctl0_r[can_mode_pkg::init_request_bit]) else $error("init request cleared early");
	AST_SLP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		ctl0_r[can_mode_pkg::sleep_request_bit] && !ctl1_r[can_mode_pkg::sleep_ack_bit] && !wake_hit
		|=> ctl0_r[can_mode_pkg::sleep_request_bit]) else $error("sleep request cleared early");
	AST_SYNC_INIT: assert property (@(posedge pclk) disable iff (!presetn)
		ctl0_r[can_mode_pkg::init_request_bit] |=> !ctl0_r[can_mode_pkg::bus_synced_flag_bit])
		else $error("sync kept in init");

	////////////////////////////////////////////////////////////////////////////////
	// status, timer and handshake checks
	sequence timer_step_seq;
		ctl0_r[can_mode_pkg::time_bit] && bus_in.bit_tick;
	endsequence
	sequence stamp_seq;
		ctl0_r[can_mode_pkg::time_bit] && bus_in.ack_seen;
	endsequence

	AST_RECEIVER_ACTIVE_FLAG_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		!bus_in.rx_busy |=> !ctl0_r[can_mode_pkg::receiver_active_flag_bit])
		else $error("receiver flag set while idle");

	AST_GATE_FREE: assert property (@(posedge pclk) disable iff (!presetn)
		!ctl0_r[can_mode_pkg::stop_in_wait_bit] |=> bus_clk_gate)
		else $error("clocks gated without stop in wait");

	AST_GATE_STOP: assert property (@(posedge pclk) disable iff (!presetn)
		bus_in.cpu_wait && ctl0_r[can_mode_pkg::stop_in_wait_bit] |=> !bus_clk_gate)
		else $error("clocks not gated in wait");

	AST_SYNC_RUN: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == can_mode_pkg::st_run && !ctl0_r[can_mode_pkg::init_request_bit]
		|=> ctl0_r[can_mode_pkg::bus_synced_flag_bit]) else $error("sync flag low while running");

	// counter wraps at 16 bits by design
	AST_TIMER_STEP: assert property (@(posedge pclk) disable iff (!presetn)
		timer_step_seq |=> timer_r == $past(timer_r) + 16'h0001)
		else $error("timer did not advance on bit tick");

	AST_STAMP: assert property (@(posedge pclk) disable iff (!presetn)
		stamp_seq |=> stamp_strobe && stamp_value == $past(timer_r))
		else $error("stamp not taken on ack");

	// wake disabled: only the cpu may end sleep
	AST_WAKE_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == can_mode_pkg::st_sleep && !ctl0_r[can_mode_pkg::wake_enable_bit]
		&& ctl0_r[can_mode_pkg::sleep_request_bit] && !ctl0_wr |=> ctl0_r[can_mode_pkg::sleep_request_bit])
		else $error("sleep left with wake disabled");

	AST_SLP_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(ctl1_r[can_mode_pkg::sleep_ack_bit]) |-> $past(bus_in.tx_empty && !bus_in.rx_busy))
		else $error("sleep entered while bus busy");

	AST_WAKE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		wake_hit |=> !ctl0_r[can_mode_pkg::sleep_request_bit] && !ctl1_r[can_mode_pkg::sleep_ack_bit])
		else $error("wake did not end sleep");

	AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
		init_req_seq && !ctl0_r[can_mode_pkg::init_request_bit] |=> abort_pulse)
		else $error("no abort on init request");

	AST_INIT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		init_mode |=> !ctl0_r[can_mode_pkg::received_frame_flag_bit] && !ctl0_r[can_mode_pkg::stop_in_wait_bit])
		else $error("control bits kept in init");

	AST_CFG_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		ctl0_r[can_mode_pkg::init_request_bit] && !ctl1_r[can_mode_pkg::init_ack_bit]
		|=> cfg_reset_pulse) else $error("register reset not signalled");

	// config bits must survive stray writes at run time
	AST_CFG_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == can_mode_pkg::ctl1_addr && !init_mode
		|=> ctl1_r[7:2] == $past(ctl1_r[7:2])) else $error("config written outside init");

	AST_RUN_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == can_mode_pkg::st_wait_sync && !run_done && !ctl0_r[can_mode_pkg::init_request_bit]
		|=> mode_r != can_mode_pkg::st_run) else $error("synced without recessive run");

	AST_TX_HELD: assert property (@(posedge pclk) disable iff (!presetn)
		ctl0_r[can_mode_pkg::init_request_bit] |=> transmit_output_pin)
		else $error("tx driven during init");

	AST_RO_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
		ctl0_wr && mode_r != can_mode_pkg::st_run |=> !ctl0_r[can_mode_pkg::bus_synced_flag_bit])
		else $error("sync flag written by cpu");
endmodule : can_mode_control

// file: bench/can_bus_model.sv
`timescale 1ns/1ps
module can_bus_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// line side
	input wire logic tx_pin,
	input wire logic go,
	// receiver front end
	output logic rx_bit,
	output logic bit_tick,
	output logic frame_ok,
	output logic rx_busy,
	output logic ack_seen
);
	logic [1:0] div_r;
	logic [4:0] left_r;
	////////////////////////////////////////
	// wired and: recessive only when every node is
	assign rx_bit = tx_pin & ~(rx_busy & left_r[0]);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 2'h0;
			left_r <= 5'h00;
			bit_tick <= 1'b0;
			frame_ok <= 1'b0;
			rx_busy <= 1'b0;
			ack_seen <= 1'b0;
		end else begin
			div_r <= div_r + 2'h1;
			bit_tick <= (div_r == 2'h3);
			frame_ok <= 1'b0;
			ack_seen <= 1'b0;
			if (go && !rx_busy) begin
				rx_busy <= 1'b1;
				left_r <= 5'h10;
			end else if (rx_busy && bit_tick) begin
				left_r <= left_r - 5'h01;
				if (left_r == 5'h01) begin
					rx_busy <= 1'b0;
					frame_ok <= 1'b1;
					ack_seen <= 1'b1;
				end
			end
		end
	end
endmodule : can_bus_model

// file: bench/can_mode_control_bench.sv
`timescale 1ns/1ps
module can_mode_control_bench;
	localparam logic [7:0] a0 = can_mode_pkg::ctl0_addr;
	localparam logic [7:0] a1 = can_mode_pkg::ctl1_addr;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic tx_bit, pin, gate, stb, abrt, go, cfgp;
	logic [15:0] sv;
	logic [7:0] c1o;
	logic rxb, tick, fok, busy, ack;
	logic tx_empty, bus_off, wake_irq, cpu_wait, loopback;
	can_mode_pkg::bus_in_t bus_in;
	int num_errors, checked, stamps, aborts, cfgs;
	assign bus_in = {rxb, tick, fok, busy, ack, tx_empty, bus_off, wake_irq, cpu_wait, loopback};
	can_mode_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_in(bus_in), .tx_bit(tx_bit), .transmit_output_pin(pin),
		.stamp_value(sv), .stamp_strobe(stb), .bus_clk_gate(gate), .abort_pulse(abrt),
		.cfg_reset_pulse(cfgp), .can_control_1_out(c1o));
	can_bus_model u_bus (.pclk(pclk), .presetn(presetn), .tx_pin(pin), .go(go), .rx_bit(rxb),
		.bit_tick(tick), .frame_ok(fok), .rx_busy(busy), .ack_seen(ack));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) num_errors++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rd
	task automatic frame;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
	endtask : frame
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (stb === 1'b1) stamps++;
		if (abrt === 1'b1) aborts++;
		if (cfgp === 1'b1) cfgs++;
	end
	initial begin
		repeat (6000) @(posedge pclk);
		num_errors++;
		wrap_up();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, go} = '0;
		{tx_empty, bus_off, wake_irq, cpu_wait, loopback, tx_bit} = 6'h21;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(a0, 32'hff, 32'h01);
		rd(a1, 32'hff, 32'h01);
		chk(pin, 1'b1);
		xfer(1'b1, a1, 32'hfc);
		rd(a1, 32'hff, 32'hfd);
		chk(c1o, 8'hfd);
		xfer(1'b1, a0, 32'h29);
		rd(a0, 32'hff, 32'h01);
		xfer(1'b1, a0, 32'h00);
		// eleven recessive bits at four cycles each, with margin
		repeat (60) @(posedge pclk);
		rd(a0, 32'hff, 32'h10);
		rd(a1, 32'h03, 32'h00);
		xfer(1'b1, a1, 32'h00);
		rd(a1, 32'hff, 32'hfc);
		xfer(1'b1, a0, 32'h58);
		rd(a0, 32'hff, 32'h18);
		frame();
		rd(a0, 32'h40, 32'h40);
		repeat (70) @(posedge pclk);
		rd(a0, 32'hc0, 32'h80);
		chk(stamps, 1);
		chk(sv != 16'h0, 1'b1);
		xfer(1'b1, a0, 32'h18);
		rd(a0, 32'h80, 32'h80);
		xfer(1'b1, a0, 32'h98);
		rd(a0, 32'h80, 32'h00);
		xfer(1'b0, can_mode_pkg::timer_addr, 32'h0);
		chk(q[15:0] != 16'h0, 1'b1);
		xfer(1'b1, a0, 32'h10);
		rd(can_mode_pkg::timer_addr, 32'hffff, 32'h0);
		frame();
		repeat (70) @(posedge pclk);
		chk(stamps, 1);
		xfer(1'b1, a0, 32'h30);
		cpu_wait <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(gate, 1'b0);
		cpu_wait <= 1'b0;
		xfer(1'b1, a0, 32'h10);
		cpu_wait <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(gate, 1'b1);
		cpu_wait <= 1'b0;
		wake_irq <= 1'b1;
		xfer(1'b1, a0, 32'h02);
		rd(a0, 32'h02, 32'h00);
		wake_irq <= 1'b0;
		frame();
		xfer(1'b1, a0, 32'h06);
		rd(a1, 32'h02, 32'h00);
		xfer(1'b1, a0, 32'h04);
		rd(a0, 32'h02, 32'h02);
		repeat (70) @(posedge pclk);
		rd(a1, 32'h02, 32'h02);
		frame();
		repeat (20) @(posedge pclk);
		rd(a0, 32'h02, 32'h00);
		xfer(1'b1, a0, 32'h02);
		repeat (70) @(posedge pclk);
		frame();
		repeat (70) @(posedge pclk);
		rd(a1, 32'h02, 32'h02);
		xfer(1'b1, a0, 32'h00);
		rd(a1, 32'h02, 32'h00);
		tx_bit <= 1'b0;
		xfer(1'b1, a0, 32'h01);
		repeat (2) @(posedge pclk);
		chk(pin, 1'b1);
		chk(aborts, 1);
		rd(a0, 32'hff, 32'h01);
		rd(a1, 32'h01, 32'h01);
		chk(cfgs, 1);
		rd(8'h14, 32'hffffffff, 32'h0);
		chk(err, 1'b1);
		wrap_up();
	end
endmodule : can_mode_control_bench
